// >>> design/ccgc_pkg.sv
// ccgc_pkg: constants for the cpu clock generator control block
// assumes nothing beyond a systemverilog compiler
package ccgc_pkg;
	localparam logic [15:0] CCGC_CPU_CLOCK_CONTROL_ADDR = 16'hFFFB;
	localparam logic [7:0] CCGC_CPU_CLOCK_CONTROL_RESET = 8'h02;
	localparam int CCGC_SLOW_SELECT_BIT = 1;
	localparam logic [7:0] CCGC_WRITE_MASK = 8'h02;
	localparam int CCGC_STAB_EXP = 15;
	localparam int CCGC_STAB_CYCLES = 1 << CCGC_STAB_EXP;
	localparam int CCGC_DIV_WIDTH = 2;
	localparam int CCGC_INSTR_PERIODS = 2;
	localparam int CCGC_FAST_TO_SLOW_MAX = 4;
	localparam int CCGC_SLOW_TO_FAST_MAX = 2;
	localparam int CCGC_PERIPH_DIV_WIDTH = 8;
	typedef enum logic [1:0] {
		CCGC_ST_RESET = 2'b00,
		CCGC_ST_WAIT = 2'b01,
		CCGC_ST_RUN = 2'b10,
		CCGC_ST_STOP = 2'b11
	} ccgc_state_e;
endpackage : ccgc_pkg

// >>> design/ccgc_divider.sv
// ccgc_divider: free-running divider on the system oscillator clock
// assumes i_osc_run gates counting; counter holds while the oscillator is stopped
`timescale 1ns/1ps
`default_nettype none
module ccgc_divider #(
	parameter int WIDTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_osc_run,
	output logic [WIDTH-1:0] o_count
);
	import ccgc_pkg::*;
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	if (WIDTH < CCGC_DIV_WIDTH) begin : g_bad_width
		$error("divider too narrow");
	end
	always_comb begin
		next_count = count;
		if (i_osc_run) begin
			next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
	assign o_count = count;
endmodule : ccgc_divider
`default_nettype wire

// >>> design/ccgc_top.sv
// ccgc_top: cpu clock generator control, one 8-bit control register
// assumes i_core_clk stands for the system oscillator clock and the cpu bus
// writes 1-bit or 8-bit accesses on i_wr_en with a bit mask in i_wr_mask
//
// Contract
// - reset loads the control register with 0x02, selecting the slow cpu clock.
// - bit 1 picks the cpu clock: 0 is the oscillator clock, 1 is that clock divided by 4.
// - the shortest instruction lasts two periods of the selected cpu clock.
// - after the select bit changes the old clock runs on, at most 4 clocks fast to slow and 2 slow to fast; the code lets up to 1 and 4 oscillator clocks pass.
// - while the reset pin is low the oscillator is held stopped.
// - on reset release the oscillator starts and a 2^15 cycle stabilisation wait runs before cpu release.
// - after the wait the cpu starts on the slow clock selected by reset.
// - peripheral clocks are divisions of the oscillator clock and stop with it.
// - the stop instruction halts the oscillator, and a halt standby mode is also offered.
// - the control register takes both single-bit and full 8-bit writes.
`timescale 1ns/1ps
`default_nettype none
module ccgc_top #(
	parameter int STAB_CYCLES = ccgc_pkg::CCGC_STAB_CYCLES,
	parameter int PERIPH_WIDTH = ccgc_pkg::CCGC_PERIPH_DIV_WIDTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_reset_n,
	input wire logic [15:0] i_addr,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_mask,
	input wire logic [7:0] i_wr_data,
	input wire logic i_stop_req,
	input wire logic i_halt_req,
	input wire logic i_wake,
	output logic [7:0] o_rd_data,
	output logic o_osc_run,
	output logic o_cpu_reset,
	output logic o_cpu_clk_en,
	output logic o_instr_tick,
	output logic o_cpu_slow,
	output logic o_halted,
	output logic [PERIPH_WIDTH-1:0] o_periph_clk
);
	import ccgc_pkg::*;
	localparam int STAB_W = $clog2(STAB_CYCLES + 1);
	if (STAB_CYCLES < 1) begin : g_bad_stab
		$error("stabilisation count must be positive");
	end
	if (PERIPH_WIDTH < CCGC_DIV_WIDTH) begin : g_bad_periph
		$error("peripheral divider too narrow");
	end
	// the slow clock is a divide by four, so the boundary compare needs a two-bit field
	if (CCGC_DIV_WIDTH != 2) begin : g_bad_div
		$error("slow divider field must be two bits");
	end
	if (CCGC_SLOW_SELECT_BIT > 7) begin : g_bad_sel
		$error("select bit outside the control register");
	end

	ccgc_state_e state, next_state;
	logic [7:0] ctrl, next_ctrl;
	logic sel_slow, next_sel_slow;
	logic [STAB_W-1:0] stab_cnt, next_stab_cnt;
	logic halted, next_halted;
	logic osc_run, next_osc_run;
	logic cpu_reset, next_cpu_reset;
	logic clk_en, next_clk_en;
	logic tick, next_tick;
	logic phase, next_phase;
	logic [7:0] rd_data, next_rd_data;
	logic [PERIPH_WIDTH-1:0] div_count;
	logic [PERIPH_WIDTH-1:0] periph, next_periph;
	logic boundary;
	logic cpu_edge;

	// oscillator runs only in the wait and run states
	ccgc_divider #(.WIDTH(PERIPH_WIDTH)) u_div (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_osc_run(next_osc_run),
		.o_count(div_count)
	);

	// old-clock boundary: fast clock edges every cycle, slow at counter wrap
	assign boundary = sel_slow ? (div_count[CCGC_DIV_WIDTH-1:0] == 2'h3) : 1'b1;
	// halt gates only the cpu enable; oscillator and peripheral clocks keep running
	assign cpu_edge = osc_run && !cpu_reset && !halted && boundary;

	function automatic logic [7:0] ccgc_merge(input logic [7:0] old_v, input logic [7:0] mask,
		input logic [7:0] data);
		ccgc_merge = ((old_v & ~mask) | (data & mask)) & CCGC_WRITE_MASK;
	endfunction : ccgc_merge

	// one address decoder shared by the write path and the read path
	function automatic logic ccgc_addr_hit(input logic [15:0] a);
		ccgc_addr_hit = (a == CCGC_CPU_CLOCK_CONTROL_ADDR);
	endfunction : ccgc_addr_hit

	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_sel_slow = sel_slow;
		next_stab_cnt = stab_cnt;
		next_halted = halted;
		next_osc_run = osc_run;
		next_cpu_reset = cpu_reset;
		if (i_wr_en && ccgc_addr_hit(i_addr)) begin
			// reserved bits forced to zero so a careless write cannot disturb them
			next_ctrl = ccgc_merge(ctrl, i_wr_mask, i_wr_data);
		end
		// select follows the register only on a boundary of the old clock, so at most
		// one old-clock period (1 fast clock fast to slow, 1 slow period = 4 fast clocks slow to fast) passes
		if (boundary) begin
			next_sel_slow = ctrl[CCGC_SLOW_SELECT_BIT];
		end
		case (state)
			CCGC_ST_RESET: begin
				next_osc_run = 1'b0;
				next_cpu_reset = 1'b1;
				next_stab_cnt = '0;
				next_halted = 1'b0;
				if (i_reset_n) begin
					next_state = CCGC_ST_WAIT;
					next_osc_run = 1'b1;
				end
			end
			CCGC_ST_WAIT: begin
				next_stab_cnt = stab_cnt + {{(STAB_W-1){1'b0}}, 1'b1};
				if (stab_cnt == STAB_W'(STAB_CYCLES - 1)) begin
					next_state = CCGC_ST_RUN;
					next_cpu_reset = 1'b0;
				end
			end
			CCGC_ST_RUN: begin
				if (i_stop_req) begin
					next_state = CCGC_ST_STOP;
					next_osc_run = 1'b0;
				end else if (i_halt_req) begin
					next_halted = 1'b1;
				end else if (i_wake) begin
					next_halted = 1'b0;
				end
			end
			CCGC_ST_STOP: begin
				// restart needs the same settling wait as power-up
				if (i_wake) begin
					next_state = CCGC_ST_WAIT;
					next_osc_run = 1'b1;
					next_stab_cnt = '0;
					next_cpu_reset = 1'b1;
				end
			end
			default: begin
				next_state = CCGC_ST_RESET;
			end
		endcase
		// the reset pin overrides every state, so the oscillator stops on the edge it goes low
		if (!i_reset_n) begin
			next_state = CCGC_ST_RESET;
			next_osc_run = 1'b0;
			next_cpu_reset = 1'b1;
			next_ctrl = CCGC_CPU_CLOCK_CONTROL_RESET;
			next_sel_slow = 1'b1;
		end
	end

	always_comb begin
		next_clk_en = cpu_edge;
		next_phase = phase;
		next_tick = 1'b0;
		if (cpu_reset) begin
			next_phase = 1'b0;
		end else if (cpu_edge) begin
			// one instruction slot spans two cpu clock periods
			next_phase = ~phase;
			next_tick = phase;
		end
		// read data shows the value after this edge, so a write reads back at once
		next_rd_data = ccgc_addr_hit(i_addr) ? next_ctrl : 8'h00;
		// peripheral tap lags the divider by one cycle and freezes on the stopping edge
		next_periph = next_osc_run ? div_count : periph;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= CCGC_ST_RESET;
			ctrl <= CCGC_CPU_CLOCK_CONTROL_RESET;
			sel_slow <= 1'b1;
			stab_cnt <= '0;
			halted <= 1'b0;
			osc_run <= 1'b0;
			cpu_reset <= 1'b1;
			clk_en <= 1'b0;
			tick <= 1'b0;
			phase <= 1'b0;
			rd_data <= 8'h00;
			periph <= '0;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			sel_slow <= next_sel_slow;
			stab_cnt <= next_stab_cnt;
			halted <= next_halted;
			osc_run <= next_osc_run;
			cpu_reset <= next_cpu_reset;
			clk_en <= next_clk_en;
			tick <= next_tick;
			phase <= next_phase;
			rd_data <= next_rd_data;
			periph <= next_periph;
		end
	end

	assign o_rd_data = rd_data;
	assign o_osc_run = osc_run;
	assign o_cpu_reset = cpu_reset;
	assign o_cpu_clk_en = clk_en;
	assign o_instr_tick = tick;
	assign o_cpu_slow = sel_slow;
	assign o_halted = halted;
	assign o_periph_clk = periph;
endmodule : ccgc_top
`default_nettype wire

// >>> verif/ccgc_top_asserts.sv
// ccgc_top_asserts: port checker for the clock control block
// assumes binding into ccgc_top
`timescale 1ns/1ps
`default_nettype none
module ccgc_top_asserts #(
	parameter int PERIPH_WIDTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_reset_n,
	input wire logic [15:0] i_addr,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_mask,
	input wire logic [7:0] i_wr_data,
	input wire logic i_stop_req,
	input wire logic [7:0] o_rd_data,
	input wire logic o_osc_run,
	input wire logic o_cpu_reset,
	input wire logic o_instr_tick,
	input wire logic o_cpu_slow,
	input wire logic o_halted,
	input wire logic [PERIPH_WIDTH-1:0] o_periph_clk
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	chk_reset_slow: assert property ($past(i_rst) |-> o_cpu_slow)
		else $error("slow not set");
	chk_rsvd_zero: assert property ((o_rd_data & 8'hFD) == 8'h00)
		else $error("reserved bit set");
	chk_osc_held: assert property (!i_reset_n |=> !o_osc_run)
		else $error("osc ran in reset");
	chk_osc_start: assert property ($rose(i_reset_n) |=> o_osc_run)
		else $error("osc not started");
	chk_tick_gap: assert property (o_instr_tick |=> !o_instr_tick)
		else $error("tick too close");
	// a fast select must land within the slow clock's four cycles plus two register stages
	chk_switch_bound: assert property (i_wr_en && i_addr == 16'hFFFB && i_wr_mask[1]
		&& !i_wr_data[1] && o_osc_run && !o_cpu_reset |-> ##[1:6] !o_cpu_slow)
		else $error("switch late");
	chk_stop_osc: assert property (i_stop_req && o_osc_run && !o_cpu_reset
		&& !o_halted |=> !o_osc_run)
		else $error("stop ignored");
	chk_periph_hold: assert property (!o_osc_run |-> $stable(o_periph_clk))
		else $error("periph ran");
endmodule : ccgc_top_asserts
bind ccgc_top ccgc_top_asserts #(.PERIPH_WIDTH(PERIPH_WIDTH)) u_ccgc_top_asserts (.*);
`default_nettype wire

// >>> verif/tb_ccgc_top.sv
// tb_ccgc_top: self-checking bench for the clock control block
// assumes the bound checker; stabilisation wait cut to 16
`timescale 1ns/1ps
`default_nettype none
module tb_ccgc_top;
	logic clk = 0, rst = 1, rst_n = 0, we = 0, stp = 0, hlt = 0, wk = 0;
	logic [15:0] addr = 16'hFFFB;
	logic [7:0] msk = 8'h00, wd = 8'h00, rd, pc, k;
	logic osc, cres, cen, tick, slow, hl;
	int miscompares = 0, cmp_count = 0, n, e, t;
	ccgc_top #(.STAB_CYCLES(16)) u_ccgc_top (.i_core_clk(clk), .i_rst(rst),
		.i_reset_n(rst_n), .i_addr(addr), .i_wr_en(we), .i_wr_mask(msk),
		.i_wr_data(wd), .i_stop_req(stp), .i_halt_req(hlt), .i_wake(wk),
		.o_rd_data(rd), .o_osc_run(osc), .o_cpu_reset(cres), .o_cpu_clk_en(cen),
		.o_instr_tick(tick), .o_cpu_slow(slow), .o_halted(hl), .o_periph_clk(pc));
	initial forever #20 clk = ~clk;
	task chk(input logic [7:0] s, input logic [7:0] x);
		cmp_count++;
		if (s !== x) begin
			miscompares++;
			$display("unexpected %0t: %h not %h", $time, s, x);
		end
	endtask : chk
	task final_report;
		if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	task cyc(input int c);
		repeat (c) @(negedge clk);
	endtask : cyc
	task wr(input logic [15:0] a, input logic [7:0] m, input logic [7:0] d);
		addr = a;
		msk = m;
		wd = d;
		we = 1;
		cyc(1);
		we = 0;
		// let an edge pass so a following write never re-raises the strobe in this step
		cyc(1);
	endtask : wr
	// 0 stop, 1 halt, 2 wake
	task pulse(input int w);
		{stp, hlt, wk} = 3'b100 >> w;
		cyc(1);
		{stp, hlt, wk} = 3'b000;
	endtask : pulse
	task wait_run;
		n = 0;
		while (cres !== 1'b0) begin
			cyc(1);
			n++;
			if (n > 99) begin
				miscompares++;
				final_report();
			end
		end
	endtask : wait_run
	task cnt(input int c);
		e = 0;
		t = 0;
		repeat (c) begin
			cyc(1);
			e += int'(cen);
			t += int'(tick);
		end
	endtask : cnt
	task t_power;
		cyc(1);
		chk(rd, 8'h02);
		chk({7'h0, osc}, 8'h00);
		rst_n = 1;
		cyc(1);
		chk({7'h0, osc}, 8'h01);
		wait_run();
		chk({7'h0, n inside {[16:17]}}, 8'h01);
		cnt(16);
		chk(8'(e), 8'h04);
		chk(8'(t), 8'h02);
		k = pc;
		cyc(4);
		chk(pc, k + 8'h04);
	endtask : t_power
	task t_speed;
		wr(16'hFFFB, 8'hFF, 8'hFF);
		chk(rd, 8'h02);
		wr(16'hFFFB, 8'h02, 8'h00);
		chk(rd, 8'h00);
		wr(16'hFF20, 8'hFF, 8'h02);
		chk(rd, 8'h00);
		addr = 16'hFFFB;
		cyc(3);
		chk({7'h0, slow}, 8'h00);
		cnt(8);
		chk(8'(e), 8'h08);
		chk(8'(t), 8'h04);
		wr(16'hFFFB, 8'hFF, 8'h02);
		cyc(2);
		chk({7'h0, slow}, 8'h01);
	endtask : t_speed
	task t_standby;
		pulse(0);
		chk({7'h0, osc}, 8'h00);
		cyc(1);
		k = pc;
		cyc(4);
		chk(pc, k);
		pulse(2);
		chk({6'h0, osc, cres}, 8'h03);
		wait_run();
		pulse(1);
		chk({7'h0, hl}, 8'h01);
		cnt(8);
		chk(8'(e), 8'h00);
		pulse(2);
		chk({7'h0, hl}, 8'h00);
	endtask : t_standby
	initial begin
		cyc(6);
		rst = 0;
		t_power();
		t_speed();
		t_standby();
		final_report();
	end
endmodule : tb_ccgc_top
`default_nettype wire
